// file: src/srabs_sequencer.sv
// rate-adapting datapath and bank command sequencer for a ddr/ddr2 controller
`timescale 1ns/1ps

module srabs_sequencer #(
  parameter bit HALF_RATE = 1'b0,
  parameter int unsigned DQ_W = 8,
  parameter int unsigned PH_W = 3,
  parameter int unsigned CLK_PERIOD_PS = srabs_pkg::CLK_PERIOD_PS
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic MEM_CLK,
  input wire logic LOCAL_REQ,
  input wire srabs_pkg::srabs_lreq_t LOCAL_ADDR,
  input wire logic [(HALF_RATE ? 4 : 2)*DQ_W-1:0] LOCAL_WDATA,
  output logic LOCAL_READY,
  output logic [(HALF_RATE ? 4 : 2)*DQ_W-1:0] LOCAL_RDATA,
  output logic LOCAL_RVALID,
  output srabs_pkg::srabs_mcmd_t MEM_CMD,
  output logic [(HALF_RATE ? 4 : 2)*DQ_W-1:0] MEM_WDATA,
  output logic [1:0] WR_PHASE,
  input wire logic [2*DQ_W-1:0] MEM_RDATA,
  input wire logic MEM_RVALID,
  input wire logic CAL_START,
  input wire logic CAL_PASS,
  input wire logic VT_EARLY,
  input wire logic VT_LATE,
  output logic [PH_W-1:0] RESYNC_PHASE,
  output logic CAL_DONE
);

  // ---------------------------------------------------------------
  // derived sizes
  // ---------------------------------------------------------------
  // local word width follows the rate setting
  localparam int unsigned LOCAL_W = (HALF_RATE ? 4 : 2) * DQ_W;
  localparam int unsigned PAIR_W = 2 * DQ_W;
  localparam int unsigned PAIRS = LOCAL_W / PAIR_W;
  // command length in controller cycles; CLOCK is the half-rate clock at half rate
  localparam int unsigned CMD_CYC =
    HALF_RATE ? srabs_pkg::CMD_CYC_HALF : srabs_pkg::CMD_CYC_FULL;
  // delay is fixed in time, so the cycle count follows the controller period
  localparam int unsigned RP_CYC =
    srabs_pkg::srabs_ceil_cyc(srabs_pkg::CLOSE_TO_OPEN_NS, CLK_PERIOD_PS);
  localparam logic [srabs_pkg::RP_CNT_W-1:0] RP_LOAD = srabs_pkg::RP_CNT_W'(RP_CYC);
  localparam logic [1:0] CMD_LAST = 2'(CMD_CYC - 1);
  localparam logic [1:0] PAIRS_CNT = 2'(PAIRS);
  localparam logic [2:0] SETTLE_LAST = 3'(srabs_pkg::CAL_SETTLE_CYC - 1);
  localparam logic [PH_W-1:0] PH_MAX = {PH_W{1'b1}};

  // ---------------------------------------------------------------
  // state records
  // ---------------------------------------------------------------
  typedef struct packed {
    srabs_pkg::srabs_seq_t seq;
    logic [1:0] cmd_cnt;
    srabs_pkg::srabs_lreq_t req;
    logic [LOCAL_W-1:0] wdata;
    logic [srabs_pkg::NBANK-1:0] open_vld;
    logic [srabs_pkg::NBANK-1:0][srabs_pkg::ROW_W-1:0] open_row;
    logic [srabs_pkg::NBANK-1:0][srabs_pkg::RP_CNT_W-1:0] rp_cnt;
    srabs_pkg::srabs_mcmd_t mcmd;
    logic [LOCAL_W-1:0] wdq;
    logic ready;
    logic rd_tgl;
    logic done_s1;
    logic done_s2;
    logic done_s3;
    logic [LOCAL_W-1:0] rdata;
    logic rvalid;
    logic [1:0] wphase;
  } srabs_ctl_st_t;

  typedef struct packed {
    logic start_s1;
    logic start_s2;
    logic start_s3;
    logic [PAIR_W-1:0] dat_s1;
    logic [PAIR_W-1:0] dat_s2;
    logic vld_s1;
    logic vld_s2;
    logic [1:0] win_cnt;
    logic [1:0] pair_cnt;
    logic [LOCAL_W-1:0] word;
    logic done_tgl;
    logic cal_s1;
    logic cal_s2;
    logic cal_s3;
    logic pass_s1;
    logic pass_s2;
    logic early_s1;
    logic early_s2;
    logic early_s3;
    logic late_s1;
    logic late_s2;
    logic late_s3;
    srabs_pkg::srabs_cal_t cal_st;
    logic [PH_W-1:0] cal_ph;
    logic [2:0] settle;
    logic found;
    logic [PH_W-1:0] first;
    logic [PH_W-1:0] last;
    logic [PH_W-1:0] phase;
    logic cal_done;
  } srabs_mem_st_t;

  srabs_ctl_st_t cq;
  srabs_ctl_st_t cd;
  srabs_mem_st_t mq;
  srabs_mem_st_t md;
  logic [1:0] rst_mem_n_q;
  logic rst_mem_n;

  // gray phase step 0, 90, 180, 270 degrees
  function automatic logic [1:0] srabs_gray_step(input logic [1:0] g);
    logic [1:0] r;
    r = {g[0], ~g[1]};
    return r;
  endfunction : srabs_gray_step

  // ---------------------------------------------------------------
  // controller clock domain
  // ---------------------------------------------------------------
  // command sequencing, bank tracking and local handshake
  always_comb
  begin
    cd = cq;
    cd.rvalid = 1'b0;
    cd.mcmd.cmd = srabs_pkg::CMD_NOP;
    cd.done_s1 = mq.done_tgl;
    cd.done_s2 = cq.done_s1;
    cd.done_s3 = cq.done_s2;
    // write lane phase from rising and falling edge pairs
    cd.wphase = srabs_gray_step(cq.wphase);
    // per-bank close-to-open countdown
    for (int b = 0; b < srabs_pkg::NBANK; b++)
    begin
      if (cq.rp_cnt[b] != '0)
      begin
        cd.rp_cnt[b] = cq.rp_cnt[b] - 1'b1;
      end
    end
    case (cq.seq)
      srabs_pkg::SEQ_IDLE:
      begin
        cd.ready = 1'b1;
        if (LOCAL_REQ && cq.ready)
        begin
          cd.req = LOCAL_ADDR;
          cd.wdata = LOCAL_WDATA;
          cd.ready = 1'b0;
          cd.cmd_cnt = 2'h0;
          if (cq.open_vld[LOCAL_ADDR.bank] &&
              cq.open_row[LOCAL_ADDR.bank] == LOCAL_ADDR.row)
          begin
            cd.seq = srabs_pkg::SEQ_ACCESS;
          end
          else if (cq.open_vld[LOCAL_ADDR.bank])
          begin
            cd.seq = srabs_pkg::SEQ_CLOSE;
          end
          else
          begin
            cd.seq = srabs_pkg::SEQ_WAIT;
          end
        end
      end
      srabs_pkg::SEQ_CLOSE:
      begin
        cd.mcmd = '{srabs_pkg::CMD_ROW_CLOSE, cq.req.bank, cq.req.row, cq.req.col};
        cd.cmd_cnt = cq.cmd_cnt + 2'h1;
        if (cq.cmd_cnt == 2'h0)
        begin
          cd.rp_cnt[cq.req.bank] = RP_LOAD;
          cd.open_vld[cq.req.bank] = 1'b0;
        end
        if (cq.cmd_cnt == CMD_LAST)
        begin
          cd.cmd_cnt = 2'h0;
          cd.seq = srabs_pkg::SEQ_WAIT;
        end
      end
      srabs_pkg::SEQ_WAIT:
      begin
        if (cq.rp_cnt[cq.req.bank] == '0)
        begin
          cd.seq = srabs_pkg::SEQ_OPEN;
        end
      end
      srabs_pkg::SEQ_OPEN:
      begin
        cd.mcmd = '{srabs_pkg::CMD_ROW_OPEN, cq.req.bank, cq.req.row, cq.req.col};
        cd.cmd_cnt = cq.cmd_cnt + 2'h1;
        if (cq.cmd_cnt == CMD_LAST)
        begin
          cd.cmd_cnt = 2'h0;
          cd.open_vld[cq.req.bank] = 1'b1;
          cd.open_row[cq.req.bank] = cq.req.row;
          cd.seq = srabs_pkg::SEQ_ACCESS;
        end
      end
      srabs_pkg::SEQ_ACCESS:
      begin
        cd.mcmd = '{cq.req.write ? srabs_pkg::CMD_WRITE : srabs_pkg::CMD_READ,
                    cq.req.bank, cq.req.row, cq.req.col};
        cd.cmd_cnt = cq.cmd_cnt + 2'h1;
        if (cq.req.write)
        begin
          cd.wdq = cq.wdata;
        end
        if (cq.cmd_cnt == CMD_LAST)
        begin
          cd.cmd_cnt = 2'h0;
          if (cq.req.write)
          begin
            cd.seq = srabs_pkg::SEQ_IDLE;
          end
          else
          begin
            cd.rd_tgl = ~cq.rd_tgl;
            cd.seq = srabs_pkg::SEQ_RDWAIT;
          end
        end
      end
      srabs_pkg::SEQ_RDWAIT:
      begin
        // returned word is stable once the toggle is seen
        if (cq.done_s2 ^ cq.done_s3)
        begin
          cd.rdata = mq.word;
          cd.rvalid = 1'b1;
          cd.seq = srabs_pkg::SEQ_IDLE;
        end
      end
      default:
      begin
        cd.seq = srabs_pkg::SEQ_IDLE;
        cd.cmd_cnt = 2'h0;
      end
    endcase
  end

  // controller state register
  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      cq <= '0;
    end
    else
    begin
      cq <= cd;
    end
  end

  // ---------------------------------------------------------------
  // link clock domain (resynchronisation clock)
  // ---------------------------------------------------------------
  // reset release aligned to the link clock
  always_ff @(posedge MEM_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rst_mem_n_q <= srabs_pkg::RST_SYNC_RST;
    end
    else
    begin
      rst_mem_n_q <= {rst_mem_n_q[0], 1'b1};
    end
  end

  assign rst_mem_n = rst_mem_n_q[1];

  // read capture, word packing, calibration and drift tracking
  always_comb
  begin
    md = mq;
    md.start_s1 = cq.rd_tgl;
    md.start_s2 = mq.start_s1;
    md.start_s3 = mq.start_s2;
    md.dat_s1 = MEM_RDATA;
    md.dat_s2 = mq.dat_s1;
    md.vld_s1 = MEM_RVALID;
    md.vld_s2 = mq.vld_s1;
    md.cal_s1 = CAL_START;
    md.cal_s2 = mq.cal_s1;
    md.cal_s3 = mq.cal_s2;
    md.pass_s1 = CAL_PASS;
    md.pass_s2 = mq.pass_s1;
    md.early_s1 = VT_EARLY;
    md.early_s2 = mq.early_s1;
    md.early_s3 = mq.early_s2;
    md.late_s1 = VT_LATE;
    md.late_s2 = mq.late_s1;
    md.late_s3 = mq.late_s2;
    // capture window opens per read; beats outside it are postamble noise
    if (mq.start_s2 ^ mq.start_s3)
    begin
      md.win_cnt = PAIRS_CNT;
      md.pair_cnt = 2'h0;
    end
    else if (mq.vld_s2 && mq.win_cnt != 2'h0)
    begin
      md.word[mq.pair_cnt*PAIR_W +: PAIR_W] = mq.dat_s2;
      md.pair_cnt = mq.pair_cnt + 2'h1;
      md.win_cnt = mq.win_cnt - 2'h1;
      if (mq.win_cnt == 2'h1)
      begin
        md.done_tgl = ~mq.done_tgl;
      end
    end
    // phase sweep and centring
    case (mq.cal_st)
      srabs_pkg::CAL_IDLE:
      begin
        if (mq.cal_s2 && !mq.cal_s3)
        begin
          md.cal_st = srabs_pkg::CAL_SWEEP;
          md.cal_ph = '0;
          md.phase = '0;
          md.settle = 3'h0;
          md.found = 1'b0;
        end
      end
      srabs_pkg::CAL_SWEEP:
      begin
        md.settle = mq.settle + 3'h1;
        if (mq.settle == SETTLE_LAST)
        begin
          md.settle = 3'h0;
          if (mq.pass_s2)
          begin
            md.found = 1'b1;
            md.last = mq.cal_ph;
            if (!mq.found)
            begin
              md.first = mq.cal_ph;
            end
          end
          if (mq.cal_ph == PH_MAX)
          begin
            md.cal_st = srabs_pkg::CAL_DONE;
            md.cal_done = 1'b1;
            md.phase = '0;
            if (mq.found || mq.pass_s2)
            begin
              md.phase = PH_W'(({1'b0, md.first} + {1'b0, md.last}) >> 1);
            end
          end
          else
          begin
            md.cal_ph = mq.cal_ph + 1'b1;
            md.phase = mq.cal_ph + 1'b1;
          end
        end
      end
      srabs_pkg::CAL_DONE:
      begin
        if (mq.cal_s2 && !mq.cal_s3)
        begin
          md.cal_st = srabs_pkg::CAL_SWEEP;
          md.cal_done = 1'b0;
          md.cal_ph = '0;
          md.phase = '0;
          md.settle = 3'h0;
          md.found = 1'b0;
        end
        else if (mq.early_s2 && !mq.early_s3 && mq.phase != '0)
        begin
          md.phase = mq.phase - 1'b1;
        end
        else if (mq.late_s2 && !mq.late_s3 && mq.phase != PH_MAX)
        begin
          md.phase = mq.phase + 1'b1;
        end
      end
      default:
      begin
        md.cal_st = srabs_pkg::CAL_IDLE;
        md.cal_done = 1'b0;
      end
    endcase
  end

  // link state register
  always_ff @(posedge MEM_CLK or negedge rst_mem_n)
  begin
    if (!rst_mem_n)
    begin
      mq <= '0;
    end
    else
    begin
      mq <= md;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign LOCAL_READY = cq.ready;
  assign LOCAL_RDATA = cq.rdata;
  assign LOCAL_RVALID = cq.rvalid;
  assign MEM_CMD = cq.mcmd;
  assign MEM_WDATA = cq.wdq;
  assign WR_PHASE = cq.wphase;
  assign RESYNC_PHASE = mq.phase;
  assign CAL_DONE = mq.cal_done;

endmodule : srabs_sequencer

// file: src/srabs_pkg.sv
// constants and types shared by the rate-adapting bank sequencer
package srabs_pkg;

  // ---------------------------------------------------------------
  // clocking and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 10000;     // controller clock, 100 MHz
  localparam int unsigned CLOSE_TO_OPEN_NS = 15;     // bank close-to-open delay
  localparam int unsigned CMD_CYC_FULL = 1;          // controller cycles per command
  localparam int unsigned CMD_CYC_HALF = 2;
  localparam int unsigned CAL_SETTLE_CYC = 4;        // link cycles per calibration step
  localparam int unsigned RP_CNT_W = 8;              // close-to-open counter width

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int unsigned BANK_W = 2;
  localparam int unsigned ROW_W = 13;
  localparam int unsigned COL_W = 10;
  localparam int unsigned NBANK = 1 << BANK_W;
  localparam logic [1:0] WPHASE_RST = 2'h0;
  localparam logic [1:0] RST_SYNC_RST = 2'h0;

  // least time rounds up to whole cycles, never below one
  function automatic int unsigned srabs_ceil_cyc(input int unsigned ns,
                                                 input int unsigned period_ps);
    int unsigned c;
    c = (ns * 1000 + period_ps - 1) / period_ps;
    return (c == 0) ? 1 : c;
  endfunction : srabs_ceil_cyc

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ROW_OPEN = 3'h1,
    CMD_ROW_CLOSE = 3'h2,
    CMD_READ = 3'h3,
    CMD_WRITE = 3'h4
  } srabs_cmd_t;

  // gray along idle, close, wait, open, access, read wait
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h0,
    SEQ_CLOSE = 3'h1,
    SEQ_WAIT = 3'h3,
    SEQ_OPEN = 3'h2,
    SEQ_ACCESS = 3'h6,
    SEQ_RDWAIT = 3'h7
  } srabs_seq_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'h0,
    CAL_SWEEP = 2'h1,
    CAL_DONE = 2'h3
  } srabs_cal_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic write;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
  } srabs_lreq_t;

  typedef struct packed {
    srabs_cmd_t cmd;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
  } srabs_mcmd_t;

endpackage : srabs_pkg

// file: tb/srabs_sequencer_assertions.sv
// port assertions for the bank sequencer
`timescale 1ns/1ps

module srabs_sequencer_assertions #(
  parameter bit HALF_RATE = 1'b0,
  parameter int unsigned DQ_W = 8
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic LOCAL_REQ,
  input wire logic [(HALF_RATE ? 4 : 2)*DQ_W-1:0] LOCAL_WDATA,
  input wire logic LOCAL_READY,
  input wire logic LOCAL_RVALID,
  input wire srabs_pkg::srabs_mcmd_t MEM_CMD,
  input wire logic [(HALF_RATE ? 4 : 2)*DQ_W-1:0] MEM_WDATA,
  input wire logic [1:0] WR_PHASE
);
  // ---------------------------------------------
  // full and half rate timing checks
  // ---------------------------------------------
  logic [(HALF_RATE ? 4 : 2)*DQ_W-1:0] wd_q;
  srabs_pkg::srabs_cmd_t c;
  assign c = MEM_CMD.cmd;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  // word captured with the taken request
  always_ff @(posedge CLOCK or negedge RESET_N)
    if (!RESET_N)
      wd_q <= '0;
    else if (LOCAL_REQ && LOCAL_READY)
      wd_q <= LOCAL_WDATA;

  a_ready_drops: assert property (LOCAL_REQ && LOCAL_READY |=> !LOCAL_READY)
    else $error("ready stayed high after a take");
  a_take_quiet: assert property (LOCAL_REQ && LOCAL_READY |=> c == srabs_pkg::CMD_NOP)
    else $error("command issued one edge after take");
  // an access may follow a row open with no idle cycle, so only a repeat is wrong
  a_cmd_single: assert property (!HALF_RATE && c != srabs_pkg::CMD_NOP |=> c != $past(c))
    else $error("command held longer than one cycle");
  a_cmd_double: assert property (HALF_RATE && c != srabs_pkg::CMD_NOP && $changed(c)
    |=> c == $past(c) ##1 c != $past(c))
    else $error("half rate command not held two cycles");
  a_close_gap: assert property (c == srabs_pkg::CMD_ROW_CLOSE |=> (c != srabs_pkg::CMD_ROW_OPEN)[*2])
    else $error("row open too soon after close");
  a_close_open: assert property (c == srabs_pkg::CMD_ROW_CLOSE |-> ##[2:8] c == srabs_pkg::CMD_ROW_OPEN)
    else $error("no row open after row close");
  a_open_access: assert property (c == srabs_pkg::CMD_ROW_OPEN
    |-> ##[1:4] (c == srabs_pkg::CMD_READ || c == srabs_pkg::CMD_WRITE))
    else $error("no access after row open");
  a_write_data: assert property (c == srabs_pkg::CMD_WRITE |-> MEM_WDATA == wd_q)
    else $error("write data differs from taken word");
  // ready comes back as the write command ends
  a_write_ready: assert property ((c == srabs_pkg::CMD_WRITE) ##1 (c != srabs_pkg::CMD_WRITE)
    |-> LOCAL_READY)
    else $error("ready low after write command");
  a_rvalid_pulse: assert property (LOCAL_RVALID |=> !LOCAL_RVALID)
    else $error("read valid longer than one cycle");
  a_phase_gray: assert property (1'b1 |=> WR_PHASE == {$past(WR_PHASE[0]), ~$past(WR_PHASE[1])})
    else $error("write phase left gray order");

  c_close: cover property (c == srabs_pkg::CMD_ROW_CLOSE);
  c_write: cover property (c == srabs_pkg::CMD_WRITE);
  c_rvalid: cover property (LOCAL_RVALID);
endmodule : srabs_sequencer_assertions

bind srabs_sequencer srabs_sequencer_assertions #(.HALF_RATE(HALF_RATE), .DQ_W(DQ_W))
  srabs_sequencer_assertions_inst (.CLOCK(CLOCK), .RESET_N(RESET_N), .LOCAL_REQ(LOCAL_REQ),
  .LOCAL_WDATA(LOCAL_WDATA), .LOCAL_READY(LOCAL_READY), .LOCAL_RVALID(LOCAL_RVALID),
  .MEM_CMD(MEM_CMD), .MEM_WDATA(MEM_WDATA), .WR_PHASE(WR_PHASE));

// file: tb/srabs_mem_model.sv
// behavioural memory device on the command and read return pins
`timescale 1ns/1ps

module srabs_mem_model #(
  parameter int RP_CYC = 2,
  parameter int LW = 16
) (
  input wire logic clk,
  input wire logic mem_clk,
  input wire logic rst_n,
  input wire srabs_pkg::srabs_mcmd_t cmd,
  input wire logic [LW-1:0] wdata,
  input wire logic [31:0] lat,
  output logic [15:0] rdata,
  output logic rvalid,
  output int n_err
);
  // ---------------------------------------------
  // bank state and storage
  // ---------------------------------------------
  logic [LW-1:0] mem [int];
  logic [LW-1:0] rd_word;
  srabs_pkg::srabs_cmd_t prev;
  logic open_q [4];
  logic [12:0] row_q [4];
  int cyc, n_rd, n_done, k;
  int close_t [4];

  // track open rows, store writes, count protocol slips
  always @(posedge clk or negedge rst_n)
  begin
    k = int'({cmd.bank, cmd.row, cmd.col});
    if (!rst_n)
    begin
      open_q = '{default: 1'b0};
      close_t = '{default: -100};
      cyc = 0;
      n_rd = 0;
      n_err = 0;
      prev = srabs_pkg::CMD_NOP;
    end
    else
    begin
      cyc = cyc + 1;
      // act once per command, however many cycles it stands
      case (cmd.cmd == prev ? srabs_pkg::CMD_NOP : cmd.cmd)
        srabs_pkg::CMD_ROW_CLOSE:
        begin
          open_q[cmd.bank] = 1'b0;
          close_t[cmd.bank] = cyc;
        end
        srabs_pkg::CMD_ROW_OPEN:
        begin
          if (open_q[cmd.bank] || cyc - close_t[cmd.bank] < RP_CYC) n_err++;
          open_q[cmd.bank] = 1'b1;
          row_q[cmd.bank] = cmd.row;
        end
        srabs_pkg::CMD_READ, srabs_pkg::CMD_WRITE:
        begin
          if (!open_q[cmd.bank] || row_q[cmd.bank] != cmd.row) n_err++;
          if (cmd.cmd == srabs_pkg::CMD_WRITE)
            mem[k] = wdata;
          else
          begin
            rd_word = mem.exists(k) ? mem[k] : '0;
            n_rd++;
          end
        end
        default: ;
      endcase
      prev = cmd.cmd;
    end
  end

  // LW/16 beat pairs after lat link cycles, then rvalid drops and rdata carries the inverted first pair
  initial
  begin
    n_done = 0;
    rvalid = 1'b0;
    rdata = 16'h0000;
    forever
    begin
      @(posedge mem_clk);
      if (n_rd != n_done)
      begin
        repeat (lat) @(posedge mem_clk);
        // earliest beat pair first
        for (int j = 0; j < LW / 16; j++)
        begin
          rvalid <= 1'b1;
          rdata <= rd_word[16*j +: 16];
          @(posedge mem_clk);
        end
        rvalid <= 1'b0;
        rdata <= ~rd_word[15:0];
        n_done++;
      end
    end
  end
endmodule : srabs_mem_model

// file: tb/testbench.sv
// self-checking bench for the bank sequencer
`timescale 1ns/1ps

module testbench;
  // ---------------------------------------------
  // signals, clocks and instances
  // ---------------------------------------------
  logic clock, mem_clk, reset_n, local_req, local_ready, local_rvalid;
  logic cal_start, cal_pass, vt_early, vt_late, cal_done, mem_rvalid;
  srabs_pkg::srabs_lreq_t local_addr;
  srabs_pkg::srabs_mcmd_t mem_cmd;
  logic [15:0] local_wdata, local_rdata, mem_wdata, mem_rdata;
  logic [1:0] wr_phase;
  logic [2:0] resync_phase;
  int n_fail, n_tests, lat, n_err, n_open, n_close;
  logic h_req, h_ready, h_rvalid, h_mrvalid;
  srabs_pkg::srabs_lreq_t h_addr;
  srabs_pkg::srabs_mcmd_t h_cmd;
  logic [31:0] h_wdata, h_rdata, h_mwdata;
  logic [15:0] h_mrdata;
  int h_err, h_open, h_close;

  srabs_sequencer #(.HALF_RATE(1'b0), .DQ_W(8), .PH_W(3), .CLK_PERIOD_PS(10000))
    srabs_sequencer_inst (.CLOCK(clock), .RESET_N(reset_n), .MEM_CLK(mem_clk),
    .LOCAL_REQ(local_req), .LOCAL_ADDR(local_addr), .LOCAL_WDATA(local_wdata),
    .LOCAL_READY(local_ready), .LOCAL_RDATA(local_rdata), .LOCAL_RVALID(local_rvalid),
    .MEM_CMD(mem_cmd), .MEM_WDATA(mem_wdata), .WR_PHASE(wr_phase), .MEM_RDATA(mem_rdata),
    .MEM_RVALID(mem_rvalid), .CAL_START(cal_start), .CAL_PASS(cal_pass),
    .VT_EARLY(vt_early), .VT_LATE(vt_late), .RESYNC_PHASE(resync_phase), .CAL_DONE(cal_done));

  srabs_mem_model #(.RP_CYC(2)) srabs_mem_model_inst (.clk(clock), .mem_clk(mem_clk),
    .rst_n(reset_n), .cmd(mem_cmd), .wdata(mem_wdata), .lat(lat), .rdata(mem_rdata),
    .rvalid(mem_rvalid), .n_err(n_err));

  // half-rate copy: control at half the memory rate, word four beats wide
  if (1)
  begin : g_half
    srabs_sequencer #(.HALF_RATE(1'b1), .DQ_W(8), .PH_W(3), .CLK_PERIOD_PS(10000))
      srabs_sequencer_inst (.CLOCK(clock), .RESET_N(reset_n), .MEM_CLK(mem_clk),
      .LOCAL_REQ(h_req), .LOCAL_ADDR(h_addr), .LOCAL_WDATA(h_wdata),
      .LOCAL_READY(h_ready), .LOCAL_RDATA(h_rdata), .LOCAL_RVALID(h_rvalid),
      .MEM_CMD(h_cmd), .MEM_WDATA(h_mwdata), .WR_PHASE(), .MEM_RDATA(h_mrdata),
      .MEM_RVALID(h_mrvalid), .CAL_START(cal_start), .CAL_PASS(cal_pass),
      .VT_EARLY(vt_early), .VT_LATE(vt_late), .RESYNC_PHASE(), .CAL_DONE());
    srabs_mem_model #(.RP_CYC(2), .LW(32)) srabs_mem_model_inst (.clk(clock),
      .mem_clk(mem_clk), .rst_n(reset_n), .cmd(h_cmd), .wdata(h_mwdata), .lat(lat),
      .rdata(h_mrdata), .rvalid(h_mrvalid), .n_err(h_err));
  end

  // capture passes on taps 2 to 6, so the centre is tap 4
  assign cal_pass = (resync_phase >= 3'h2) && (resync_phase <= 3'h6);

  // controller clock and unrelated link clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    mem_clk = 1'b0;
    #7;
    forever #32 mem_clk = ~mem_clk;
  end

  // bank command counters
  always @(posedge clock)
  begin
    if (mem_cmd.cmd === srabs_pkg::CMD_ROW_OPEN) n_open++;
    if (mem_cmd.cmd === srabs_pkg::CMD_ROW_CLOSE) n_close++;
    if (h_cmd.cmd === srabs_pkg::CMD_ROW_OPEN) h_open++;
    if (h_cmd.cmd === srabs_pkg::CMD_ROW_CLOSE) h_close++;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one request, judged on bank commands and returned word
  task automatic access(input logic wr, input logic [1:0] b, input logic [12:0] r,
    input logic [9:0] col, input logic [15:0] d, input int eo, input int ec);
    int i, o, c;
    o = n_open;
    c = n_close;
    for (i = 0; i < 300 && local_ready !== 1'b1; i++) @(negedge clock);
    local_addr = '{wr, b, r, col};
    local_wdata = d;
    local_req = 1'b1;
    @(negedge clock);
    local_req = 1'b0;
    for (i = 0; i < 300 && (wr ? local_ready : local_rvalid) !== 1'b1; i++) @(negedge clock);
    check("handshake", 32'(i < 300), 32'h0000_0001);
    if (!wr) check("read word", 32'(local_rdata), 32'(d));
    check("row opens", o + eo - n_open, 32'h0000_0000);
    check("row closes", c + ec - n_close, 32'h0000_0000);
  endtask : access

  task automatic t_banks;
    access(1'b1, 2'h0, 13'h0005, 10'h001, 16'hA5A5, 1, 0);
    access(1'b1, 2'h0, 13'h0005, 10'h002, 16'h5A5A, 0, 0);
    access(1'b0, 2'h0, 13'h0005, 10'h001, 16'hA5A5, 0, 0);
    access(1'b1, 2'h1, 13'h0009, 10'h000, 16'h1234, 1, 0);
    access(1'b0, 2'h0, 13'h0005, 10'h002, 16'h5A5A, 0, 0);
    access(1'b1, 2'h0, 13'h1FFF, 10'h3FF, 16'h0F0F, 1, 1);
    access(1'b0, 2'h0, 13'h0005, 10'h001, 16'hA5A5, 1, 1);
    $display("banks test done");
  endtask : t_banks

  task automatic t_slow;
    lat = 20;
    access(1'b0, 2'h1, 13'h0009, 10'h000, 16'h1234, 0, 0);
    lat = 6;
    $display("slow return test done");
  endtask : t_slow

  // half rate request on bank 2; each bank command counted in cycles
  task automatic acc_h(input logic wr, input logic [12:0] r, input logic [31:0] d,
    input int eo, input int ec);
    int i, o, c;
    o = h_open;
    c = h_close;
    for (i = 0; i < 300 && h_ready !== 1'b1; i++) @(negedge clock);
    h_addr = '{wr, 2'h2, r, 10'h004};
    h_wdata = d;
    h_req = 1'b1;
    @(negedge clock);
    h_req = 1'b0;
    for (i = 0; i < 300 && (wr ? h_ready : h_rvalid) !== 1'b1; i++) @(negedge clock);
    check("half handshake", 32'(i < 300), 32'h0000_0001);
    if (!wr) check("half read word", h_rdata, d);
    check("half opens", 32'(h_open - o), 32'(2 * eo));
    check("half closes", 32'(h_close - c), 32'(2 * ec));
  endtask : acc_h

  task automatic t_half;
    acc_h(1'b1, 13'h0003, 32'h8765_4321, 1, 0);
    acc_h(1'b0, 13'h0003, 32'h8765_4321, 0, 0);
    acc_h(1'b1, 13'h0004, 32'h0F1E_2D3C, 1, 1);
    acc_h(1'b0, 13'h0003, 32'h8765_4321, 1, 1);
    $display("half rate test done");
  endtask : t_half

  // link-side pulse long enough for the two-flop synchroniser
  task automatic pulse(input int sel);
    if (sel == 0) cal_start = 1'b1;
    if (sel == 1) vt_late = 1'b1;
    if (sel == 2) vt_early = 1'b1;
    repeat (30) @(negedge clock);
    cal_start = 1'b0;
    vt_late = 1'b0;
    vt_early = 1'b0;
    repeat (30) @(negedge clock);
  endtask : pulse

  task automatic t_cal;
    int i;
    pulse(0);
    for (i = 0; i < 600 && cal_done !== 1'b1; i++) @(negedge clock);
    check("cal done", 32'(cal_done), 32'h0000_0001);
    check("centre tap", 32'(resync_phase), 32'h0000_0004);
    pulse(1);
    check("late step", 32'(resync_phase), 32'h0000_0005);
    pulse(2);
    pulse(2);
    check("early steps", 32'(resync_phase), 32'h0000_0003);
    $display("calibration test done");
  endtask : t_cal

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  // main sequence
  initial
  begin
    reset_n = 1'b0;
    local_req = 1'b0;
    local_addr = '0;
    local_wdata = 16'h0000;
    h_req = 1'b0;
    h_addr = '0;
    h_wdata = 32'h0000_0000;
    cal_start = 1'b0;
    vt_early = 1'b0;
    vt_late = 1'b0;
    lat = 6;
    repeat (3) @(posedge mem_clk);
    @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    t_banks;
    t_slow;
    t_half;
    t_cal;
    check("device slips", 32'(n_err + h_err), 32'h0000_0000);
    finish_test;
  end

  // watchdog
  initial
  begin
    #60000;
    n_fail++;
    finish_test;
  end
endmodule : testbench
